// File: logic/pct_pkg.sv
// Purpose: Shared constants and types for the instruction timing core
// Assumes: One system clock; code bytes arrive one per handshake
// Notes: All cycle counts are whole system clocks
package pct_pkg;

  // Field widths
  localparam int W_CYC = 4;
  localparam int W_BYTES = 2;

  // Cycle counts of the classes whose time differs from their length
  localparam logic [3:0] ONE_CYCLE = 4'h1;
  localparam logic [3:0] MAX_CYCLES = 4'h8;
  localparam logic [3:0] MUL_CYCLES = 4'h4;
  localparam logic [3:0] DIV_CYCLES = 4'h8;
  localparam logic [3:0] XMOVE_CYCLES = 4'h3;
  localparam logic [3:0] INDIRECT_CYCLES = 4'h2;
  localparam logic [3:0] RETURN_CYCLES = 4'h5;
  localparam logic [3:0] LONG_JUMP_CYCLES = 4'h4;
  localparam logic [3:0] SHORT_JUMP_CYCLES = 4'h3;
  localparam logic [3:0] CMP_INDIRECT_CYCLES = 4'h4;

  // Opcodes with special handling
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_UNUSED = 8'ha5;
  localparam logic [7:0] OP_MUL = 8'ha4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_INC_DATA_POINTER = 8'ha3;

  // Values after reset
  localparam logic [7:0] RESET_OPCODE = 8'h00;
  localparam logic [1:0] RESET_BYTES = 2'h1;
  localparam logic [3:0] RESET_CYCLES = 4'h1;

  typedef enum logic [2:0] {
    KIND_PLAIN = 3'h0,
    KIND_COND = 3'h1,
    KIND_XREAD = 3'h2,
    KIND_XWRITE = 3'h3,
    KIND_CODE = 3'h4,
    KIND_NOP = 3'h5
  } pct_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_EXEC = 2'h2
  } pct_state_t;

endpackage

// File: logic/pct_timing_rom.sv
// Purpose: Opcode table giving length, base cycle count and class
// Assumes: Read data registered; read only when i_rd_en is high
// Notes: Base count of a conditional branch is its not-taken time
`timescale 1ns/1ns
`default_nettype none
module pct_timing_rom (
  // Clock, reset and clock enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  // Read port
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  // Registered read data
  output logic [1:0] o_bytes,
  output logic [3:0] o_cycles,
  output pct_pkg::pct_kind_t o_kind
);

  function automatic logic [8:0] decode(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    logic [1:0] b;
    logic [3:0] c;
    pct_pkg::pct_kind_t k;
    hi = op[7:4];
    lo = op[3:0];
    k = pct_pkg::KIND_PLAIN;
    // Standard opcode map, lengths by column
    if (lo >= 4'h8) begin // RULE5
      b = (hi inside {4'h7, 4'h8, 4'ha, 4'hd}) ? 2'h2 : (hi == 4'hb) ? 2'h3 : 2'h1;
    end else if (lo == 4'h6 || lo == 4'h7) begin
      b = (hi inside {4'h7, 4'h8, 4'ha}) ? 2'h2 : (hi == 4'hb) ? 2'h3 : 2'h1;
    end else if (lo == 4'h5) begin
      b = (hi inside {4'h7, 4'h8, 4'hb, 4'hd}) ? 2'h3 : (hi == 4'ha) ? 2'h1 : 2'h2;
    end else if (lo == 4'h4) begin
      b = (hi inside {4'h0, 4'h1, 4'h8, 4'ha, 4'hc, 4'hd, 4'he, 4'hf}) ? 2'h1 :
          (hi == 4'hb) ? 2'h3 : 2'h2;
    end else if (lo == 4'h3) begin // RULE9 RULE10
      b = (hi inside {4'h4, 4'h5, 4'h6}) ? 2'h3 : 2'h1;
    end else if (lo == 4'h2) begin
      b = (hi inside {4'h0, 4'h1}) ? 2'h3 : (hi inside {4'h2, 4'h3, 4'he, 4'hf}) ? 2'h1 : 2'h2;
    end else if (lo == 4'h1) begin
      b = 2'h2;
    end else begin
      b = (hi inside {4'h1, 4'h2, 4'h3, 4'h9}) ? 2'h3 : (hi inside {4'h0, 4'he, 4'hf}) ? 2'h1 : 2'h2;
    end
    // Time equals length unless overridden
    c = {2'h0, b}; // RULE2
    if ((lo == 4'h6 || lo == 4'h7) && b == 2'h1) begin // RULE8 RULE11
      c = pct_pkg::INDIRECT_CYCLES;
    end
    if (op == pct_pkg::OP_MUL) begin // RULE4
      c = pct_pkg::MUL_CYCLES;
    end else if (op == pct_pkg::OP_DIV) begin // RULE4
      c = pct_pkg::DIV_CYCLES;
    end else if (op == 8'h22 || op == 8'h32) begin
      c = pct_pkg::RETURN_CYCLES;
    end else if (op == 8'h02 || op == 8'h12) begin
      c = pct_pkg::LONG_JUMP_CYCLES;
    end else if (lo == 4'h1 || op == 8'h80 || op == 8'h73) begin
      c = pct_pkg::SHORT_JUMP_CYCLES;
    end else if (op == 8'h83 || op == 8'h93) begin // RULE7
      c = pct_pkg::XMOVE_CYCLES;
      k = pct_pkg::KIND_CODE;
    end else if ((hi == 4'he || hi == 4'hf) && (lo inside {4'h0, 4'h2, 4'h3})) begin // RULE6
      c = pct_pkg::XMOVE_CYCLES;
      k = (hi == 4'he) ? pct_pkg::KIND_XREAD : pct_pkg::KIND_XWRITE;
    end else if (op == 8'hb6 || op == 8'hb7) begin // RULE12
      c = pct_pkg::CMP_INDIRECT_CYCLES;
      k = pct_pkg::KIND_COND;
    end else if ((lo == 4'h0 && (hi inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7})) ||
                 (hi == 4'hb && lo >= 4'h4) || op == 8'hd5 ||
                 (hi == 4'hd && lo >= 4'h8)) begin // RULE3
      k = pct_pkg::KIND_COND;
    end else if (op == pct_pkg::OP_NOP || op == pct_pkg::OP_UNUSED) begin // RULE14
      b = 2'h1;
      c = pct_pkg::ONE_CYCLE;
      k = pct_pkg::KIND_NOP;
    end
    return {k, b, c};
  endfunction

  logic [8:0] entry;

  assign entry = decode(i_addr);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_kind <= pct_pkg::KIND_NOP;
      o_bytes <= pct_pkg::RESET_BYTES;
      o_cycles <= pct_pkg::RESET_CYCLES;
    end else if (i_enable && i_rd_en) begin
      o_kind <= pct_pkg::pct_kind_t'(entry[8:6]);
      o_bytes <= entry[5:4];
      o_cycles <= entry[3:0];
    end
  end

endmodule
`default_nettype wire

// File: logic/pct_timing_core.sv
// Purpose: Instruction sequencer timing each opcode in single system clocks
// Assumes: Code bytes, condition and address come from logic on i_clock
// Notes: The opcode table is read as each byte enters the one-byte hold stage so rate stays one per clock
// Contract
// [RULE1] Every instruction is timed in plain clock cycles, no machine cycles.
// [RULE2] Most instructions execute in as many cycles as they have bytes.
// [RULE3] A conditional branch not taken finishes one cycle sooner than taken.
// [RULE4] No instruction exceeds eight cycles; divide takes eight, multiply four.
// [RULE5] Opcodes, addressing modes and flag effects match the classic set.
// [RULE6] External data move reaches on-chip RAM, off-chip space or program flash.
// [RULE7] Software reads flash by code byte move and writes it by external move.
// [RULE8] Add, add-carry, subtract-borrow: register 1/1, direct 2/2, indirect 1/2, immediate 2/2.
// [RULE9] AND and OR immediate into direct byte take three bytes, three cycles.
// [RULE10] Data pointer increment is one byte and one cycle.
// [RULE11] Increment or decrement: indirect 1/2, register 1/1, direct 2/2.
// [RULE12] 109 instructions with the documented spread of cycle counts.
// [RULE13] Single-cycle instructions issue back to back, one per clock.
// [RULE14] The single unused opcode behaves exactly as no-operation.
`timescale 1ns/1ns
`default_nettype none
module pct_timing_core #(
  parameter int XRAM_BYTES = 4096
) (
  // Clock, reset and clock enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  // Code byte stream
  input wire logic i_code_valid,
  input wire logic [7:0] i_code_byte,
  output logic o_code_ready,
  // Branch condition exchange
  output logic o_cond_query,
  input wire logic i_cond_true,
  // External move target inputs
  input wire logic [15:0] i_ext_addr,
  input wire logic i_store_write_en,
  // Instruction status
  output logic o_instr_start,
  output logic o_instr_done,
  output logic [7:0] o_opcode,
  output logic [1:0] o_bytes_used,
  output logic [3:0] o_cycles_used,
  output logic o_branch_taken,
  // External and flash strobes
  output logic o_xram_sel,
  output logic o_offchip_sel,
  output logic o_flash_rd,
  output logic o_flash_wr,
  output logic o_ext_write
);

  if (XRAM_BYTES < 1 || XRAM_BYTES > 65536) begin : g_bad_size
    $error("XRAM_BYTES must be between 1 and 65536");
  end

  localparam logic [16:0] XRAM_LIMIT = 17'(XRAM_BYTES);

  // Hold stage and table output
  logic hold_valid_r;
  logic [7:0] hold_byte_r;
  logic [1:0] rom_bytes;
  logic [3:0] rom_cycles;
  pct_pkg::pct_kind_t rom_kind;

  // Execution state
  pct_pkg::pct_state_t state_r;
  logic [3:0] rem_r;
  logic [1:0] oper_r;
  logic cond_r;
  logic taken_r;
  logic [3:0] used_r;
  logic [3:0] base_r;
  logic [1:0] bytes_r;
  logic [7:0] opcode_r;
  logic plain_r;

  // Handshake terms
  logic is_idle;
  logic is_exec;
  logic starved;
  logic progress;
  logic take_op;
  logic take_oper;
  logic take_hold;
  logic load_hold;
  logic cond_hit;
  logic last_exec;
  logic single;
  logic ext_move;

  assign is_idle = (state_r == pct_pkg::ST_IDLE);
  assign is_exec = (state_r == pct_pkg::ST_EXEC);
  assign take_op = i_enable & is_idle & hold_valid_r;
  assign starved = (oper_r != 2'h0) & ~hold_valid_r;
  assign progress = i_enable & is_exec & ~starved; // RULE1
  assign take_oper = progress & (oper_r != 2'h0);
  assign take_hold = take_op | take_oper;
  assign o_code_ready = i_enable & (~hold_valid_r | take_hold); // RULE13
  assign load_hold = i_code_valid & o_code_ready;
  assign o_cond_query = progress & cond_r & ~taken_r & (rem_r == pct_pkg::ONE_CYCLE);
  assign cond_hit = o_cond_query & i_cond_true; // RULE3
  assign last_exec = progress & (rem_r == pct_pkg::ONE_CYCLE) & ~cond_hit;
  assign single = take_op & (rom_cycles == pct_pkg::ONE_CYCLE); // RULE13
  assign ext_move = (rom_kind == pct_pkg::KIND_XREAD) | (rom_kind == pct_pkg::KIND_XWRITE);

  // Opcode table looked up as each byte enters the hold stage
  pct_timing_rom u_rom (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(i_enable),
    .i_rd_en(load_hold),
    .i_addr(i_code_byte),
    .o_bytes(rom_bytes),
    .o_cycles(rom_cycles),
    .o_kind(rom_kind)
  );

  // Hold stage
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hold_valid_r <= 1'b0;
      hold_byte_r <= pct_pkg::RESET_OPCODE;
    end else if (i_enable) begin
      if (load_hold) begin
        hold_valid_r <= 1'b1;
        hold_byte_r <= i_code_byte;
      end else if (take_hold) begin
        hold_valid_r <= 1'b0;
      end
    end
  end

  // Sequencer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= pct_pkg::ST_IDLE;
    end else if (i_enable) begin
      case (state_r)
        pct_pkg::ST_IDLE: begin
          if (take_op && !single) begin
            state_r <= pct_pkg::ST_EXEC;
          end
        end
        pct_pkg::ST_EXEC: begin
          if (last_exec) begin
            state_r <= pct_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= pct_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Cycle and operand counters
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rem_r <= pct_pkg::RESET_CYCLES;
      oper_r <= 2'h0;
      cond_r <= 1'b0;
      taken_r <= 1'b0;
      used_r <= pct_pkg::RESET_CYCLES;
      base_r <= pct_pkg::RESET_CYCLES;
      bytes_r <= pct_pkg::RESET_BYTES;
      opcode_r <= pct_pkg::RESET_OPCODE;
      plain_r <= 1'b1;
    end else if (take_op) begin
      rem_r <= rom_cycles - pct_pkg::ONE_CYCLE; // RULE2
      oper_r <= rom_bytes - 2'h1;
      cond_r <= (rom_kind == pct_pkg::KIND_COND);
      taken_r <= 1'b0;
      used_r <= pct_pkg::ONE_CYCLE; // RULE1
      base_r <= rom_cycles;
      bytes_r <= rom_bytes;
      opcode_r <= hold_byte_r;
      plain_r <= (rom_cycles == {2'h0, rom_bytes});
    end else if (progress) begin
      rem_r <= cond_hit ? rem_r : rem_r - pct_pkg::ONE_CYCLE; // RULE3
      oper_r <= take_oper ? oper_r - 2'h1 : oper_r;
      taken_r <= taken_r | cond_hit;
      used_r <= used_r + pct_pkg::ONE_CYCLE; // RULE1
    end
  end

  // Retire report
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_instr_start <= 1'b0;
      o_instr_done <= 1'b0;
      o_opcode <= pct_pkg::RESET_OPCODE;
      o_bytes_used <= pct_pkg::RESET_BYTES;
      o_cycles_used <= pct_pkg::RESET_CYCLES;
      o_branch_taken <= 1'b0;
    end else if (i_enable) begin
      o_instr_start <= take_op;
      o_instr_done <= single | last_exec;
      if (single) begin
        o_opcode <= hold_byte_r;
        o_bytes_used <= rom_bytes;
        o_cycles_used <= pct_pkg::ONE_CYCLE;
        o_branch_taken <= 1'b0;
      end else if (last_exec) begin
        o_opcode <= opcode_r;
        o_bytes_used <= bytes_r;
        o_cycles_used <= used_r + pct_pkg::ONE_CYCLE;
        o_branch_taken <= taken_r;
      end
    end
  end

  // External move and flash strobes, one pulse after the opcode cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_xram_sel <= 1'b0;
      o_offchip_sel <= 1'b0;
      o_flash_rd <= 1'b0;
      o_flash_wr <= 1'b0;
      o_ext_write <= 1'b0;
    end else if (i_enable) begin
      o_flash_rd <= take_op & (rom_kind == pct_pkg::KIND_CODE); // RULE7
      o_flash_wr <= take_op & (rom_kind == pct_pkg::KIND_XWRITE) & i_store_write_en; // RULE7
      o_ext_write <= take_op & (rom_kind == pct_pkg::KIND_XWRITE);
      o_xram_sel <= take_op & ext_move & ~((rom_kind == pct_pkg::KIND_XWRITE) & i_store_write_en)
                    & ({1'b0, i_ext_addr} < XRAM_LIMIT); // RULE6
      o_offchip_sel <= take_op & ext_move & ~((rom_kind == pct_pkg::KIND_XWRITE) & i_store_write_en)
                       & ({1'b0, i_ext_addr} >= XRAM_LIMIT); // RULE6
    end
  end

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_query_hit;
    i_enable && o_cond_query && i_cond_true;
  endsequence

  sequence s_query_miss;
    i_enable && o_cond_query && !i_cond_true;
  endsequence

  a_single_cycle_retire: assert property (single |=> o_instr_done && o_cycles_used == 4'h1) // RULE1
    else $error("single cycle instruction did not retire in one clock");
  a_cycles_equal_bytes: assert property (o_instr_done && plain_r && !o_branch_taken |-> // RULE2
    o_cycles_used == {2'h0, o_bytes_used})
    else $error("cycle count differs from byte count");
  a_branch_taken_time: assert property (s_query_hit ##1 i_enable |=> // RULE3
    o_instr_done && o_branch_taken && o_cycles_used == base_r + 4'h1)
    else $error("taken branch did not add exactly one cycle");
  a_branch_miss_time: assert property (s_query_miss |=> // RULE3
    o_instr_done && !o_branch_taken && o_cycles_used == base_r)
    else $error("untaken branch did not finish at its base count");
  a_cycle_ceiling: assert property (o_instr_done |-> o_cycles_used <= 4'h8 && o_cycles_used != 4'h0) // RULE4
    else $error("instruction exceeded eight cycles");
  a_mul_div_time: assert property (take_op && (hold_byte_r == 8'ha4 || hold_byte_r == 8'h84) |-> // RULE4
    rom_cycles == ((hold_byte_r == 8'h84) ? 4'h8 : 4'h4))
    else $error("multiply or divide base time wrong");
  a_ext_one_target: assert property (take_op && ext_move |=> // RULE6
    $onehot({o_xram_sel, o_offchip_sel, o_flash_wr}))
    else $error("external move did not pick exactly one target");
  a_flash_write_gate: assert property (o_flash_wr |-> o_ext_write && $past(i_store_write_en)) // RULE7
    else $error("flash write without store enable");
  a_code_read: assert property (take_op && rom_kind == pct_pkg::KIND_CODE |=> o_flash_rd && !o_ext_write) // RULE7
    else $error("code byte move did not read flash");
  a_arith_timing: assert property (take_op && (hold_byte_r[7:4] inside {4'h2, 4'h3, 4'h9}) // RULE8
    && hold_byte_r[3:0] >= 4'h5 |->
    (hold_byte_r[3] ? (rom_bytes == 2'h1 && rom_cycles == 4'h1) :
     (hold_byte_r[3:1] == 3'h3) ? (rom_bytes == 2'h1 && rom_cycles == 4'h2) :
     (rom_bytes == 2'h2 && rom_cycles == 4'h2)))
    else $error("arithmetic timing wrong");
  a_logic_imm_direct: assert property (take_op && (hold_byte_r == 8'h43 || hold_byte_r == 8'h53) |-> // RULE9
    rom_bytes == 2'h3 && rom_cycles == 4'h3 ##1 !o_instr_done ##1 i_enable |=> o_instr_done)
    else $error("logical immediate to direct timing wrong");
  a_data_pointer_increment: assert property (take_op && hold_byte_r == 8'ha3 |-> // RULE10
    rom_bytes == 2'h1 ##1 o_instr_done && o_cycles_used == 4'h1)
    else $error("data pointer increment not single cycle");
  a_incdec_timing: assert property (take_op && hold_byte_r[7:5] == 3'h0 && hold_byte_r[3:0] >= 4'h5 |-> // RULE11
    (hold_byte_r[3] ? (rom_bytes == 2'h1 && rom_cycles == 4'h1) :
     (hold_byte_r[3:1] == 3'h3) ? (rom_bytes == 2'h1 && rom_cycles == 4'h2) :
     (rom_bytes == 2'h2 && rom_cycles == 4'h2)))
    else $error("increment or decrement timing wrong");
  a_full_rate: assert property (single ##1 i_enable && hold_valid_r |=> o_instr_start) // RULE13
    else $error("single cycle instructions not issued back to back");
  a_unused_is_nop: assert property (take_op && hold_byte_r == 8'ha5 |-> // RULE14
    rom_kind == pct_pkg::KIND_NOP && rom_bytes == 2'h1 && rom_cycles == 4'h1)
    else $error("unused opcode not treated as no-operation");

endmodule
`default_nettype wire

// File: testbench/test_pipelined_cpu_instruction_timing.sv
// Purpose: Self-checking bench for the instruction timing core
// Assumes: Classic eight-bit opcode encodings; XRAM_BYTES left at 4096
// Notes: Driver queues expected results, monitors pop them on done or strobe
`timescale 1ns/1ns
`default_nettype none
module test_pipelined_cpu_instruction_timing;
  typedef struct {logic [7:0] op; logic [1:0] len; logic [3:0] cyc; logic tk;} pct_note_t;
  typedef struct {logic [15:0] addr; logic we; logic [4:0] vec;} pct_ext_t;
  logic i_clock, i_rst, i_enable, i_code_valid, i_cond_true, i_store_write_en;
  logic [7:0] i_code_byte;
  logic [15:0] i_ext_addr;
  logic o_code_ready, o_cond_query, o_instr_start, o_instr_done, o_branch_taken;
  logic [7:0] o_opcode;
  logic [1:0] o_bytes_used;
  logic [3:0] o_cycles_used;
  logic o_xram_sel, o_offchip_sel, o_flash_rd, o_flash_wr, o_ext_write;
  int bad_count = 0;
  int samples_checked = 0;
  int since_start = 0;
  int run = 0;
  int max_run = 0;
  logic [31:0] rnd = 32'hbd90bb88;
  logic gap_en = 1'b1;
  pct_note_t note_q[$];
  logic cond_q[$];
  pct_ext_t ext_q[$];
  // Opcode, address, store enable, {xram, offchip, flash_rd, flash_wr, ext_write}
  logic [29:0] ext_tab [9] = '{{8'hf0, 16'h0010, 1'b0, 5'h11}, {8'hf0, 16'h0fff, 1'b0, 5'h11},
    {8'hf0, 16'h1000, 1'b0, 5'h09}, {8'he0, 16'h1000, 1'b1, 5'h08},
    {8'he0, 16'h0000, 1'b0, 5'h10}, {8'hf0, 16'h2000, 1'b1, 5'h03},
    {8'hf2, 16'h0080, 1'b0, 5'h11}, {8'h93, 16'h0000, 1'b0, 5'h04},
    {8'h83, 16'h0000, 1'b0, 5'h04}};
  // Opcode, length, not-taken cycles
  logic [13:0] br_tab [10] = '{{8'h40, 2'h2, 4'h2}, {8'h50, 2'h2, 4'h2}, {8'h60, 2'h2, 4'h2},
    {8'h70, 2'h2, 4'h2}, {8'hd8, 2'h2, 4'h2}, {8'h20, 2'h3, 4'h3}, {8'h10, 2'h3, 4'h3},
    {8'hb4, 2'h3, 4'h3}, {8'hd5, 2'h3, 4'h3}, {8'hb6, 2'h3, 4'h4}};
  logic [13:0] misc_tab [8] = '{{8'h53, 2'h3, 4'h3}, {8'h43, 2'h3, 4'h3}, {8'ha3, 2'h1, 4'h1},
    {8'ha4, 2'h1, 4'h4}, {8'h84, 2'h1, 4'h8}, {8'h00, 2'h1, 4'h1}, {8'ha5, 2'h1, 4'h1},
    {8'h04, 2'h1, 4'h1}};
  logic [7:0] ar_tab [3] = '{8'h20, 8'h30, 8'h90};

  pct_timing_core #(.XRAM_BYTES(4096)) dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable),
    .i_code_valid(i_code_valid), .i_code_byte(i_code_byte), .o_code_ready(o_code_ready),
    .o_cond_query(o_cond_query), .i_cond_true(i_cond_true),
    .i_ext_addr(i_ext_addr), .i_store_write_en(i_store_write_en),
    .o_instr_start(o_instr_start), .o_instr_done(o_instr_done), .o_opcode(o_opcode),
    .o_bytes_used(o_bytes_used), .o_cycles_used(o_cycles_used),
    .o_branch_taken(o_branch_taken), .o_xram_sel(o_xram_sel),
    .o_offchip_sel(o_offchip_sel), .o_flash_rd(o_flash_rd), .o_flash_wr(o_flash_wr),
    .o_ext_write(o_ext_write)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Holds the byte and valid until an edge where ready and enable are high
  task automatic send_byte(input logic [7:0] b);
    int t;
    t = 0;
    i_code_valid <= 1'b1;
    i_code_byte <= b;
    do begin
      @(posedge i_clock);
      t++;
    end while (!(o_code_ready === 1'b1 && i_enable === 1'b1) && t < 100);
    if (t >= 100) chk(16'h0, 16'h1);
  endtask

  task automatic issue(input logic [7:0] op, input logic [1:0] len, input logic [3:0] cyc,
                       input logic br, input logic tk);
    pct_note_t n;
    n.op = op;
    n.len = len;
    n.cyc = cyc + {3'h0, tk};
    n.tk = tk;
    rnd = lfsr(rnd);
    if (gap_en && rnd[2:0] == 3'h0) begin
      i_code_valid <= 1'b0;
      @(posedge i_clock);
    end
    if (br) cond_q.push_back(tk);
    note_q.push_back(n);
    send_byte(op);
    for (int k = 1; k < len; k++) begin
      rnd = lfsr(rnd);
      send_byte(rnd[15:8]);
    end
  endtask

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    #1000000;
    bad_count++;
    close_out();
  end

  // Result monitor: one note per done, counted on enabled edges only
  always @(posedge i_clock) begin
    pct_note_t n;
    if (!i_rst && i_enable === 1'b1) begin
      since_start <= (o_instr_start === 1'b1) ? 0 : since_start + 1;
      run <= (o_instr_done === 1'b1) ? run + 1 : 0;
      if (o_instr_done === 1'b1) begin
        if (run + 1 > max_run) max_run <= run + 1;
        if (note_q.size() == 0) chk(16'h0, 16'h1);
        else begin
          n = note_q.pop_front();
          chk({1'b0, o_opcode, o_bytes_used, o_cycles_used, o_branch_taken},
              {1'b0, n.op, n.len, n.cyc, n.tk});
          chk(16'((o_instr_start === 1'b1) ? 0 : since_start + 1), 16'(n.cyc - 4'h1));
        end
      end
    end
  end

  // Condition driver: answers each query from the queue
  always @(posedge i_clock) begin
    if (i_enable === 1'b1 && o_cond_query === 1'b1) begin
      if (cond_q.size() == 0) chk(16'h0, 16'h1);
      else void'(cond_q.pop_front());
    end
    if (cond_q.size() > 0) i_cond_true <= cond_q[0];
  end

  // Target driver and strobe monitor
  always @(posedge i_clock) begin
    pct_ext_t e;
    if (i_enable === 1'b1 &&
        {o_xram_sel, o_offchip_sel, o_flash_rd, o_flash_wr, o_ext_write} !== 5'h00) begin
      if (ext_q.size() == 0) chk(16'h1, 16'h0);
      else begin
        e = ext_q.pop_front();
        chk(16'({o_xram_sel, o_offchip_sel, o_flash_rd, o_flash_wr, o_ext_write}),
            16'(e.vec));
      end
    end
    if (ext_q.size() > 0) begin
      i_ext_addr <= ext_q[0].addr;
      i_store_write_en <= ext_q[0].we;
    end
  end

  initial begin
    pct_ext_t e;
    i_rst = 1'b1;
    i_enable = 1'b1;
    i_code_valid = 1'b0;
    i_code_byte = 8'h00;
    i_cond_true = 1'b0;
    i_ext_addr = 16'h0000;
    i_store_write_en = 1'b0;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    // Arithmetic and increment/decrement forms
    for (int b = 0; b < 3; b++) begin
      rnd = lfsr(rnd);
      issue(ar_tab[b] | {5'h01, rnd[2:0]}, 2'h1, 4'h1, 1'b0, 1'b0);
      issue(ar_tab[b] | 8'h05, 2'h2, 4'h2, 1'b0, 1'b0);
      issue(ar_tab[b] | {7'h03, rnd[3]}, 2'h1, 4'h2, 1'b0, 1'b0);
      issue(ar_tab[b] | 8'h04, 2'h2, 4'h2, 1'b0, 1'b0);
      if (b < 2) begin
        issue({3'h0, b[0], 1'b1, rnd[6:4]}, 2'h1, 4'h1, 1'b0, 1'b0);
        issue({3'h0, b[0], 4'h5}, 2'h2, 4'h2, 1'b0, 1'b0);
        issue({3'h0, b[0], 3'h3, rnd[7]}, 2'h1, 4'h2, 1'b0, 1'b0);
      end
    end
    for (int m = 0; m < 8; m++) issue(misc_tab[m][13:6], misc_tab[m][5:4], misc_tab[m][3:0], 1'b0, 1'b0);
    // Branches not taken, then the same branches taken
    for (int t = 0; t < 2; t++) begin
      for (int j = 0; j < 10; j++) issue(br_tab[j][13:6], br_tab[j][5:4], br_tab[j][3:0], 1'b1, t[0]);
    end
    // External and code moves, boundary addresses included
    for (int x = 0; x < 9; x++) begin
      e.addr = ext_tab[x][21:6];
      e.we = ext_tab[x][5];
      e.vec = ext_tab[x][4:0];
      ext_q.push_back(e);
      issue(ext_tab[x][29:22], 2'h1, 4'h3, 1'b0, 1'b0);
    end
    // Divide waiting in the hold stage while the clock enable is dropped for three clocks
    issue(8'h84, 2'h1, 4'h8, 1'b0, 1'b0);
    i_enable <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_enable <= 1'b1;
    // Unbroken run of single-cycle instructions
    gap_en = 1'b0;
    for (int r = 0; r < 10; r++) begin
      rnd = lfsr(rnd);
      issue(ar_tab[r % 3] | {5'h01, rnd[2:0]}, 2'h1, 4'h1, 1'b0, 1'b0);
    end
    i_code_valid <= 1'b0;
    for (int w = 0; w < 300 && note_q.size() > 0; w++) @(posedge i_clock);
    chk(16'(note_q.size()), 16'h0);
    chk(16'(ext_q.size() + cond_q.size()), 16'h0);
    chk(16'(max_run >= 10), 16'h1);
    close_out();
  end
endmodule
`default_nettype wire
